// ---- src/gpio_port_defs.vh ----
// Purpose: Constants for the general-purpose port block
// Assumes: AXI4-Lite slave, 32-bit data, one word per register
// Notes: Byte addresses; per-port registers repeat every PORT_STRIDE
`ifndef GPIO_PORT_DEFS_VH
`define GPIO_PORT_DEFS_VH

`define NUM_PORTS 5
`define PORT_WIDTH 8
`define PORT_STRIDE 12'h010
`define OFF_DIR 12'h000
`define OFF_PORT 12'h004
`define OFF_LAT 12'h008
`define OFF_OD1 12'h100
`define OFF_OD2 12'h104
`define OFF_OD3 12'h108
`define OFF_PADCFG 12'h10C
`define OFF_PERIPH_EN 12'h110
`define OD1_MASK 8'hFF
`define OD2_MASK 8'h0F
`define OD3_MASK 8'h03
`define PAD_TTL_BIT 0
`define PAD_MASK 8'h07
`define DIR_RESET 8'hFF
`define LAT_RESET 8'h00
`define OD_RESET 8'h00
`define PAD_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- src/pin_sync.v ----
// Purpose: Two-flop synchroniser for a bus of pin levels
// Assumes: Single clock domain, asynchronous active-high reset
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_sync_out
);
  reg [WIDTH-1:0] stage1;

  // Two stages to settle metastability before register reads
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= {WIDTH{1'b0}};
      pin_sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pin_in;
      pin_sync_out <= stage1;
    end
  end
endmodule // pin_sync

// ---- src/gpio_port.v ----
// Purpose: General-purpose ports with direction, pin and latch registers
// Assumes: AXI4-Lite register access, 100 MHz clk, pins asynchronous
// Notes: Pin outputs are registered; open-drain per peripheral group
`timescale 1ns/10ps
`include "gpio_port_defs.vh"

// Behaviour
// - Up to five ports are provided, the count being a parameter.
// - Each port has a direction, a pin-read and an output latch register.
// - Reading the pin register returns sampled pin levels.
// - Reading the latch register returns the latched drive value.
// - An enabled peripheral takes over its pin from the port logic.
// - With latch 0, the direction bit alone drives low or releases.
// - Open drain exists on serial, SPI and capture/compare pins.
// - Each peripheral module has its own open-drain bit; else push-pull.
// - Open drain follows the pin that a routed output is assigned to.
// - Setting the TTL select bit makes parallel port inputs TTL.
// - With the TTL select bit clear, parallel inputs use Schmitt buffers.
// - Direction 1 is input with driver off; 0 drives the latch value.
// - Writing the pin register updates the output latch.
// - An open-drain bit of 1 enables open drain; it resets to 0.
// - The TTL select is bit 0 of the pad configuration, reset 0.
module gpio_port #(
  parameter NUM_PORTS = `NUM_PORTS,
  parameter PW = `PORT_WIDTH
) (
  input wire clk,
  input wire sys_rst,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NUM_PORTS*PW-1:0] pin_in,
  output reg [NUM_PORTS*PW-1:0] pin_out,
  output reg [NUM_PORTS*PW-1:0] pin_oe,
  input wire [NUM_PORTS*PW-1:0] periph_sel,
  input wire [NUM_PORTS*PW-1:0] periph_out,
  input wire [NUM_PORTS*PW-1:0] periph_oe,
  input wire [NUM_PORTS*PW*4-1:0] periph_od_src,
  output reg parallel_port_ttl_select,
  output reg [NUM_PORTS*PW-1:0] parallel_port_schmitt_en
);
  localparam N = NUM_PORTS * PW;

  reg [N-1:0] pin_direction;
  reg [N-1:0] output_data_latch;
  reg [7:0] open_drain_control1;
  reg [7:0] open_drain_control2;
  reg [7:0] open_drain_control3;
  reg [7:0] pad_configuration;
  reg [N-1:0] parallel_pins;
  wire [N-1:0] pin_level;
  reg [N-1:0] next_pin_out;
  reg [N-1:0] next_pin_oe;
  reg [15:0] od_bits;
  reg [11:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  reg [31:0] rd_word;
  reg rd_ok;
  reg wr_ok;
  integer i;

  // Port index of an address, or 4'hF when outside the port area
  // The map has room for fifteen ports; port 15 would decode as 4'hF, and more would alias in the nibble
  function [3:0] port_of;
    input [11:0] addr;
    begin
      if (addr[11:4] < NUM_PORTS)
        port_of = addr[7:4];
      else
        port_of = 4'hF;
    end
  endfunction

  // Byte-lane merge of write data into an 8-bit register
  function [7:0] merge8;
    input [7:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge8 = strb[0] ? data[7:0] : old;
    end
  endfunction

  // Byte-lane merge of a full word; lanes without strobe keep old bits
  function [31:0] merge32;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        merge32[k*8 +: 8] = strb[k] ? data[k*8 +: 8] : old[k*8 +: 8];
    end
  endfunction

  // Pin levels synchronised before any read
  pin_sync #(.WIDTH(N)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(pin_in),
    .pin_sync_out(pin_level)
  );

  // Gather module open-drain bits into one 16-entry lookup
  // Entries 0 and 1 stay clear: those sources never go open drain
  always @* begin
    od_bits = {open_drain_control3[1:0], open_drain_control2[3:0],
      open_drain_control1, 2'b00};
  end

  // Pin drive: peripheral override, then open drain, then port latch
  always @* begin
    next_pin_out = {N{1'b0}};
    next_pin_oe = {N{1'b0}};
    for (i = 0; i < N; i = i + 1) begin
      if (periph_sel[i]) begin
        // Open-drain bit chosen by the pin's current routing
        if (od_bits[periph_od_src[i*4 +: 4]]) begin
          // Driver only ever pulls low; a high level is left to the pull-up
          next_pin_out[i] = 1'b0;
          next_pin_oe[i] = periph_oe[i] & ~periph_out[i];
        end else begin
          next_pin_out[i] = periph_out[i];
          next_pin_oe[i] = periph_oe[i];
        end
      end else begin
        // Latch 0 plus direction toggling gives a pull-up friendly line
        next_pin_out[i] = output_data_latch[i];
        next_pin_oe[i] = ~pin_direction[i];
      end
    end
  end

  // Registered pin drive and buffer selection
  // Registered so the pads never see decode glitches
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_out <= {N{1'b0}};
      pin_oe <= {N{1'b0}};
      parallel_port_ttl_select <= 1'b0;
      parallel_port_schmitt_en <= {N{1'b0}};
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      parallel_port_ttl_select <= pad_configuration[`PAD_TTL_BIT];
      // Schmitt used on parallel pins unless TTL selected
      parallel_port_schmitt_en <= pad_configuration[`PAD_TTL_BIT] ?
        {N{1'b0}} : parallel_pins;
    end
  end

  // Read mux; unmapped addresses answer with an error
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (port_of(s_axi_araddr) != 4'hF) begin
      // Sub-register of the port in the low nibble
      case (s_axi_araddr[3:0])
        4'h0: rd_word[7:0] = pin_direction[port_of(s_axi_araddr)*PW +: PW];
        4'h4: rd_word[7:0] = pin_level[port_of(s_axi_araddr)*PW +: PW];
        4'h8: rd_word[7:0] =
          output_data_latch[port_of(s_axi_araddr)*PW +: PW];
        default: rd_ok = 1'b0;
      endcase
    end else begin
      // Shared registers; the parallel-pin mask is write-only
      case (s_axi_araddr)
        `OFF_OD1: rd_word[7:0] = open_drain_control1;
        `OFF_OD2: rd_word[7:0] = open_drain_control2;
        `OFF_OD3: rd_word[7:0] = open_drain_control3;
        `OFF_PADCFG: rd_word[7:0] = pad_configuration;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Write address decode, shared with the parallel-pin map
  always @* begin
    wr_ok = (port_of(aw_addr) != 4'hF) ?
      (aw_addr[3:0] == 4'h0 || aw_addr[3:0] == 4'h4 ||
       aw_addr[3:0] == 4'h8) :
      (aw_addr == `OFF_OD1 || aw_addr == `OFF_OD2 ||
       aw_addr == `OFF_OD3 || aw_addr == `OFF_PADCFG ||
       aw_addr == `OFF_PERIPH_EN);
  end

  // AXI write channel: address and data taken in either order
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      // All pins inputs, latches clear, push-pull everywhere
      pin_direction <= {NUM_PORTS{`DIR_RESET}};
      output_data_latch <= {NUM_PORTS{`LAT_RESET}};
      open_drain_control1 <= `OD_RESET;
      open_drain_control2 <= `OD_RESET;
      open_drain_control3 <= `OD_RESET;
      pad_configuration <= `PAD_RESET;
      parallel_pins <= {N{1'b0}};
    end else begin
      // Address half
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      // Data half
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // Commit once both halves are held; one write at a time
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        if (port_of(aw_addr) != 4'hF) begin
          case (aw_addr[3:0])
            4'h0: pin_direction[port_of(aw_addr)*PW +: PW] <=
              merge8(pin_direction[port_of(aw_addr)*PW +: PW],
                w_data, w_strb);
            // Both pin and latch writes land in the latch
            4'h4, 4'h8: output_data_latch[port_of(aw_addr)*PW +: PW] <=
              merge8(output_data_latch[port_of(aw_addr)*PW +: PW],
                w_data, w_strb);
            default: ;
          endcase
        end else begin
          case (aw_addr)
            `OFF_OD1: open_drain_control1 <=
              merge8(open_drain_control1, w_data, w_strb) & `OD1_MASK;
            `OFF_OD2: open_drain_control2 <=
              merge8(open_drain_control2, w_data, w_strb) & `OD2_MASK;
            `OFF_OD3: open_drain_control3 <=
              merge8(open_drain_control3, w_data, w_strb) & `OD3_MASK;
            `OFF_PADCFG: pad_configuration <=
              merge8(pad_configuration, w_data, w_strb) & `PAD_MASK;
            // Marks which pins carry parallel-port inputs (first 32)
            `OFF_PERIPH_EN: parallel_pins[31:0] <=
              merge32(parallel_pins[31:0], w_data, w_strb);
            default: ;
          endcase
        end
      end
      // Response taken: reopen both halves
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI read channel: one cycle to answer, held until rready
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      // Data captured at the take, so it stands while rvalid waits
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        // Answer taken: ready for the next address
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // gpio_port

// ---- verif/pin_load.sv ----
// Purpose: Pin loads, each pin pulled up, some pulled low outside
// Assumes: One pull-up per pin
// Notes: On contention the device's drive wins
`timescale 1ns/10ps
module pin_load #(
  parameter N = 40
) (
  input wire [N-1:0] pin_out,
  input wire [N-1:0] pin_oe,
  input wire [N-1:0] ext_low,
  output wire [N-1:0] pin_in
);
  // Released pins show the pull-up, or low where ext_low is set, never the last driven value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ~ext_low);
endmodule // pin_load

// ---- verif/gpio_port_checker.sv ----
// Purpose: Bus handshake and pad checks at the port boundary
// Assumes: One clock, async high reset
// Notes: Register contents are judged by the bench
`timescale 1ns/10ps
module gpio_port_checker #(
  parameter NUM_PORTS = 5,
  parameter PW = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NUM_PORTS*PW-1:0] pin_out,
  input wire [NUM_PORTS*PW-1:0] pin_oe,
  input wire [NUM_PORTS*PW-1:0] periph_sel,
  input wire [NUM_PORTS*PW-1:0] periph_out,
  input wire [NUM_PORTS*PW-1:0] periph_oe,
  input wire [NUM_PORTS*PW*4-1:0] periph_od_src,
  input wire parallel_port_ttl_select,
  input wire [NUM_PORTS*PW-1:0] parallel_port_schmitt_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Write answer comes within two edges of both halves
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid) else $error("rvalid dropped early");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready) else $error("write not closed");
  a_aw_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read overlap");
  a_ttl_buffer: assert property (parallel_port_ttl_select
    |-> parallel_port_schmitt_en == 0) else $error("schmitt left on");
  // Owned push-pull pins copy the peripheral once inputs settle
  a_periph_push: assert property ((&periph_sel && periph_od_src == 0
    && $stable(periph_out) && $stable(periph_oe))[*2]
    |-> pin_out == periph_out && pin_oe == periph_oe)
    else $error("peripheral drive not passed");
endmodule // gpio_port_checker

bind gpio_port gpio_port_checker #(.NUM_PORTS(NUM_PORTS), .PW(PW))
  gpio_port_checker_inst (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pin_out,
  .pin_oe, .periph_sel, .periph_out, .periph_oe, .periph_od_src,
  .parallel_port_ttl_select, .parallel_port_schmitt_en);

// ---- verif/gpio_port_pad_options_tb.sv ----
// Purpose: Register-level tests of the port block
// Assumes: Pull-ups on every pin
// Notes: Pin outputs settle two edges after a write
`timescale 1ns/10ps
`include "gpio_port_defs.vh"
module gpio_port_pad_options_tb;
  logic clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [39:0] periph_sel = 0, periph_out = 0, periph_oe = 0, ext_low = 0;
  logic [159:0] periph_od_src = 0;
  logic [1:0] wresp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, parallel_port_ttl_select;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [39:0] pin_in, pin_out, pin_oe, parallel_port_schmitt_en;
  int bad_count = 0, samples_checked = 0;
  gpio_port gpio_port_inst (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .periph_sel,
    .periph_out, .periph_oe, .periph_od_src, .parallel_port_ttl_select,
    .parallel_port_schmitt_en);
  pin_load pin_load_inst (.pin_out, .pin_oe, .ext_low, .pin_in);
  always #5 clk = ~clk;
  // Compare and count
  task automatic chk(input string w, input logic [39:0] g, e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  // Write with both halves offered together; a hang counts as a mismatch
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    wresp = s_axi_bresp;
    if (s_axi_bvalid !== 1'b1) begin
      chk("bvalid", s_axi_bvalid, 40'h1);
      summarize();
    end
    // Let an edge pass so the next call never re-drives bready at once
    @(posedge clk);
  endtask
  // Read, then compare data and response
  task automatic rc(input string w, input logic [11:0] a,
                    input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) begin
      chk("rvalid", s_axi_rvalid, 40'h1);
      summarize();
    end
    chk(w, s_axi_rdata, e);
    chk("rresp", s_axi_rresp, er);
    @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int p = 0; p < 5; p++) begin
      rc("dir", p * 16, 32'h000000FF, `RESP_OKAY);
      rc("lat", p * 16 + 8, 32'h0, `RESP_OKAY);
    end
    rc("od1", `OFF_OD1, 32'h0, `RESP_OKAY);
    rc("pad", `OFF_PADCFG, 32'h0, `RESP_OKAY);
    chk("oe", pin_oe, 40'h0);
    $display("test reset done");
    // Port write lands in the latch; port read shows the pins
    wr(`PORT_STRIDE + `OFF_PORT, 32'h000000A5);
    ext_low <= 40'h0000003C00;
    repeat (3) @(posedge clk);
    rc("pin1", `PORT_STRIDE + `OFF_PORT, 32'h000000C3, `RESP_OKAY);
    rc("lat1", `PORT_STRIDE + `OFF_LAT, 32'h000000A5, `RESP_OKAY);
    ext_low <= 40'h0;
    wr(`PORT_STRIDE + `OFF_DIR, 32'h0);
    repeat (3) @(posedge clk);
    chk("oe1", pin_oe[15:8], 40'hFF);
    chk("out1", pin_out[15:8], 40'hA5);
    // Latch cleared: direction alone pulls low or releases
    wr(`PORT_STRIDE + `OFF_LAT, 32'h0);
    wr(`PORT_STRIDE + `OFF_DIR, 32'h000000FE);
    repeat (3) @(posedge clk);
    chk("oe1", pin_oe[15:8], 40'h01);
    rc("pin1", `PORT_STRIDE + `OFF_PORT, 32'h000000FE, `RESP_OKAY);
    $display("test port done");
    rc("hole", 12'h200, 32'h0, `RESP_SLVERR);
    wr(12'h200, 32'h000000FF);
    chk("bresp", wresp, `RESP_SLVERR);
    wr(`OFF_OD2, 32'h000000FF);
    rc("od2", `OFF_OD2, 32'h0000000F, `RESP_OKAY);
    wr(`OFF_OD3, 32'h000000FF);
    rc("od3", `OFF_OD3, 32'h00000003, `RESP_OKAY);
    // Buffer select for the parallel port inputs
    wr(`OFF_PERIPH_EN, 32'h000000FF);
    wr(`OFF_PADCFG, 32'h00000001);
    repeat (3) @(posedge clk);
    chk("ttl", parallel_port_ttl_select, 40'h1);
    chk("st", parallel_port_schmitt_en, 40'h0);
    wr(`OFF_PADCFG, 32'h0);
    repeat (3) @(posedge clk);
    chk("st", parallel_port_schmitt_en, 40'hFF);
    $display("test pad done");
    // Peripheral owns every pin, push-pull first
    periph_sel <= '1;
    periph_oe <= '1;
    periph_out <= {5{8'h5A}};
    repeat (4) @(posedge clk);
    chk("out", pin_out, {5{8'h5A}});
    periph_od_src[3:0] <= 4'h2;
    wr(`OFF_OD1, 32'h00000001);
    repeat (3) @(posedge clk);
    chk("oe0", pin_oe[1:0], 40'h3);
    periph_od_src[7:4] <= 4'h2;
    repeat (3) @(posedge clk);
    chk("oe1", pin_oe[1:0], 40'h1);
    wr(`OFF_OD1, 32'h0);
    repeat (3) @(posedge clk);
    chk("oe1", pin_oe[1:0], 40'h3);
    $display("test peripheral done");
    // Reset in mid-run puts direction and open-drain bits back
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rc("od3", `OFF_OD3, 32'h0, `RESP_OKAY);
    rc("dir1", `PORT_STRIDE + `OFF_DIR, 32'h000000FF, `RESP_OKAY);
    $display("test second reset done");
    summarize();
  end
endmodule // gpio_port_pad_options_tb
